// >>> common/energy_acc_pkg.sv
// Constants and carrier types for the per-phase energy accumulator bank
package energy_acc_pkg;
    localparam int NUM_PHASES = 3;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;

    // Byte addresses, index 0 = phase A, 1 = B, 2 = C
    localparam logic [2:0][ADDR_W-1:0] RMS_CURRENT_OFS =
        {10'h3A4, 10'h2B8, 10'h1CC};
    localparam logic [2:0][ADDR_W-1:0] REAL_POS_OFS =
        {10'h3C0, 10'h2D4, 10'h1E8};
    localparam logic [2:0][ADDR_W-1:0] REAL_NEG_OFS =
        {10'h3C4, 10'h2D8, 10'h1EC};
    localparam logic [2:0][ADDR_W-1:0] REACT_POS_OFS =
        {10'h3C8, 10'h2DC, 10'h1F0};
    localparam logic [2:0][ADDR_W-1:0] OVF_FLAGS_OFS =
        {10'h31E, 10'h232, 10'h146};

    // Overflow flag bit positions
    localparam int REAL_POS_OVF_BIT = 0;
    localparam int REAL_NEG_OVF_BIT = 1;
    localparam int REACT_POS_OVF_BIT = 2;

    // Reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RMS_RESET = 32'h0000_0000;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // Results of one DSP cycle for one phase
    typedef struct packed {
        logic signed [DATA_W-1:0] signed_real_power;
        logic signed [DATA_W-1:0] signed_reactive_power;
        logic [DATA_W-1:0] rms_current_value;
    } phase_in_s;

    typedef struct packed {
        logic [DATA_W-1:0] rms_current_value;
        logic [DATA_W-1:0] real_positive_energy;
        logic [DATA_W-1:0] real_negative_energy;
        logic [DATA_W-1:0] reactive_positive_energy;
        logic [2:0] energy_overflow_flags;
    } phase_state_s;

    // Host register access port
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [ADDR_W-1:0] addr;
        logic [FLAG_W-1:0] wr_data;
    } host_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
    } host_rsp_s;
endpackage : energy_acc_pkg

// >>> logic/phase_energy_accumulators.sv
// Per-phase RMS current, energy accumulators and overflow flags
`timescale 1ns/100ps
module phase_energy_accumulators (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // DSP results, one strobe per DSP cycle
    input wire logic dsp_cycle_done,
    input energy_acc_pkg::phase_in_s [2:0] phase_in,
    // Host register access
    input energy_acc_pkg::host_req_s host_req,
    output energy_acc_pkg::host_rsp_s host_rsp
);
    import energy_acc_pkg::*;

    typedef struct packed {
        phase_state_s [2:0] ph;
        host_rsp_s rsp;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic [2:0] pos_carry;
    logic [2:0] neg_carry;
    logic [2:0] rpos_carry;

    // Sum with the carry out on top; the carry marks a wrap
    function automatic logic [DATA_W:0] add_wrap(
        input logic [DATA_W-1:0] acc,
        input logic [DATA_W-1:0] inc
    );
        add_wrap = {1'b0, acc} + {1'b0, inc};
    endfunction : add_wrap

    // Magnitude of a negative value; the most negative input still fits
    function automatic logic [DATA_W-1:0] magnitude(
        input logic signed [DATA_W-1:0] v
    );
        magnitude = DATA_W'(~v + 1'b1);
    endfunction : magnitude

    always_comb begin
        logic [DATA_W:0] sum;
        logic [2:0] clr;
        sum = '0;
        clr = '0;
        state_next = state_reg;
        state_next.rsp.rd_valid = 1'b0;
        state_next.rsp.rd_data = '0;
        pos_carry = '0;
        neg_carry = '0;
        rpos_carry = '0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            if (dsp_cycle_done) begin
                state_next.ph[p].rms_current_value =
                    phase_in[p].rms_current_value;
                if (phase_in[p].signed_real_power > 0) begin
                    sum = add_wrap(state_reg.ph[p].real_positive_energy,
                        phase_in[p].signed_real_power);
                    state_next.ph[p].real_positive_energy =
                        sum[DATA_W-1:0];
                    pos_carry[p] = sum[DATA_W];
                end
                if (phase_in[p].signed_real_power < 0) begin
                    sum = add_wrap(state_reg.ph[p].real_negative_energy,
                        magnitude(phase_in[p].signed_real_power));
                    state_next.ph[p].real_negative_energy =
                        sum[DATA_W-1:0];
                    neg_carry[p] = sum[DATA_W];
                end
                if (phase_in[p].signed_reactive_power > 0) begin
                    sum = add_wrap(
                        state_reg.ph[p].reactive_positive_energy,
                        phase_in[p].signed_reactive_power);
                    state_next.ph[p].reactive_positive_energy =
                        sum[DATA_W-1:0];
                    rpos_carry[p] = sum[DATA_W];
                end
            end
            // Write-one-to-clear; a same-cycle overflow wins over the clear
            clr = '0;
            if (host_req.wr_en && host_req.addr == OVF_FLAGS_OFS[p]) begin
                clr[REAL_POS_OVF_BIT] = host_req.wr_data[REAL_POS_OVF_BIT];
                clr[REAL_NEG_OVF_BIT] = host_req.wr_data[REAL_NEG_OVF_BIT];
                clr[REACT_POS_OVF_BIT] =
                    host_req.wr_data[REACT_POS_OVF_BIT];
            end
            state_next.ph[p].energy_overflow_flags =
                state_reg.ph[p].energy_overflow_flags & ~clr;
            if (pos_carry[p]) begin
                state_next.ph[p].energy_overflow_flags[REAL_POS_OVF_BIT] =
                    1'b1;
            end
            if (neg_carry[p]) begin
                state_next.ph[p].energy_overflow_flags[REAL_NEG_OVF_BIT] =
                    1'b1;
            end
            if (rpos_carry[p]) begin
                state_next.ph[p].energy_overflow_flags[REACT_POS_OVF_BIT] =
                    1'b1;
            end
        end
        // Reads return values as they stood before this edge
        if (host_req.rd_en) begin
            state_next.rsp.rd_valid = 1'b1;
            for (int p = 0; p < NUM_PHASES; p++) begin
                if (host_req.addr == RMS_CURRENT_OFS[p]) begin
                    state_next.rsp.rd_data =
                        state_reg.ph[p].rms_current_value;
                end
                if (host_req.addr == REAL_POS_OFS[p]) begin
                    state_next.rsp.rd_data =
                        state_reg.ph[p].real_positive_energy;
                end
                if (host_req.addr == REAL_NEG_OFS[p]) begin
                    state_next.rsp.rd_data =
                        state_reg.ph[p].real_negative_energy;
                end
                if (host_req.addr == REACT_POS_OFS[p]) begin
                    state_next.rsp.rd_data =
                        state_reg.ph[p].reactive_positive_energy;
                end
                if (host_req.addr == OVF_FLAGS_OFS[p]) begin
                    state_next.rsp.rd_data = {29'h0,
                        state_reg.ph[p].energy_overflow_flags};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                state_reg.ph[p].rms_current_value <= RMS_RESET;
                state_reg.ph[p].real_positive_energy <= ACC_RESET;
                state_reg.ph[p].real_negative_energy <= ACC_RESET;
                state_reg.ph[p].reactive_positive_energy <= ACC_RESET;
                state_reg.ph[p].energy_overflow_flags <= FLAGS_RESET;
            end
            state_reg.rsp <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign host_rsp = state_reg.rsp;

    // Checks on phase A; the three phases share one code path
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_real_pos_wrap;
        dsp_cycle_done && pos_carry[0];
    endsequence
    sequence s_read_req;
        host_req.rd_en && host_req.addr == REACT_POS_OFS[0];
    endsequence

    property p_rms_latch;
        dsp_cycle_done |=> state_reg.ph[0].rms_current_value ==
            $past(phase_in[0].rms_current_value);
    endproperty
    a_rms_latch: assert property (p_rms_latch)
        else $error("rms current not latched");

    property p_real_pos_add;
        dsp_cycle_done && phase_in[0].signed_real_power > 0 |=>
            state_reg.ph[0].real_positive_energy ==
            DATA_W'($past(state_reg.ph[0].real_positive_energy) +
            $past(phase_in[0].signed_real_power));
    endproperty
    a_real_pos_add: assert property (p_real_pos_add)
        else $error("real positive sum wrong");

    property p_real_pos_hold;
        !(dsp_cycle_done && phase_in[0].signed_real_power > 0) |=>
            $stable(state_reg.ph[0].real_positive_energy);
    endproperty
    a_real_pos_hold: assert property (p_real_pos_hold)
        else $error("real positive moved without cause");

    property p_real_pos_flag;
        s_real_pos_wrap |=> state_reg.ph[0].real_positive_energy <
            $past(state_reg.ph[0].real_positive_energy) &&
            state_reg.ph[0].energy_overflow_flags[REAL_POS_OVF_BIT];
    endproperty
    a_real_pos_flag: assert property (p_real_pos_flag)
        else $error("real positive wrap not flagged");

    property p_real_neg_add;
        dsp_cycle_done && phase_in[0].signed_real_power < 0 |=>
            state_reg.ph[0].real_negative_energy ==
            DATA_W'($past(state_reg.ph[0].real_negative_energy) -
            $past(phase_in[0].signed_real_power));
    endproperty
    a_real_neg_add: assert property (p_real_neg_add)
        else $error("real negative sum wrong");

    // A sum wraps when the old value exceeds the complement of the step
    property p_real_neg_flag;
        dsp_cycle_done && phase_in[0].signed_real_power < 0 &&
            state_reg.ph[0].real_negative_energy >
            ~magnitude(phase_in[0].signed_real_power) |=>
            state_reg.ph[0].energy_overflow_flags[REAL_NEG_OVF_BIT];
    endproperty
    a_real_neg_flag: assert property (p_real_neg_flag)
        else $error("real negative wrap not flagged");

    property p_react_pos_add;
        dsp_cycle_done && phase_in[0].signed_reactive_power > 0 |=>
            state_reg.ph[0].reactive_positive_energy ==
            DATA_W'($past(state_reg.ph[0].reactive_positive_energy) +
            $past(phase_in[0].signed_reactive_power));
    endproperty
    a_react_pos_add: assert property (p_react_pos_add)
        else $error("reactive positive sum wrong");

    property p_react_pos_flag;
        dsp_cycle_done && phase_in[0].signed_reactive_power > 0 &&
            state_reg.ph[0].reactive_positive_energy >
            ~unsigned'(phase_in[0].signed_reactive_power) |=>
            state_reg.ph[0].energy_overflow_flags[REACT_POS_OVF_BIT];
    endproperty
    a_react_pos_flag: assert property (p_react_pos_flag)
        else $error("reactive positive wrap not flagged");

    property p_flag_sticky;
        state_reg.ph[0].energy_overflow_flags[REAL_POS_OVF_BIT] &&
            !(host_req.wr_en && host_req.addr == OVF_FLAGS_OFS[0]) |=>
            state_reg.ph[0].energy_overflow_flags[REAL_POS_OVF_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag dropped by itself");

    property p_read_back;
        s_read_req ##0 1'b1 |=> host_rsp.rd_valid &&
            host_rsp.rd_data ==
            $past(state_reg.ph[0].reactive_positive_energy);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("register read returned wrong value");
endmodule : phase_energy_accumulators

// >>> tb/host_model.sv
// Host side model: register reads, flag clears, energy deltas
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic clk,
    // Register port
    output energy_acc_pkg::host_req_s host_req,
    input energy_acc_pkg::host_rsp_s host_rsp
);
    import energy_acc_pkg::*;
    initial begin
        host_req = '0;
    end
    // Answer is sampled once the taking edge has landed
    task automatic rd(input logic [ADDR_W-1:0] a,
        output logic [DATA_W-1:0] d, output logic v);
        @(posedge clk);
        #1;
        host_req.rd_en = 1'b1;
        host_req.addr = a;
        @(posedge clk);
        #1;
        host_req.rd_en = 1'b0;
        v = host_rsp.rd_valid;
        d = host_rsp.rd_data;
    endtask : rd
    // Only the host may drop a flag
    task automatic clr(input logic [ADDR_W-1:0] a, input logic [7:0] m);
        @(posedge clk);
        #1;
        host_req.wr_en = 1'b1;
        host_req.addr = a;
        host_req.wr_data = m;
        @(posedge clk);
        #1;
        host_req.wr_en = 1'b0;
    endtask : clr
    // Usage since last reading, corrected across a flagged wrap
    function automatic logic [32:0] energy_delta(input logic [31:0] prev,
        input logic [31:0] cur, input logic ovf);
        energy_delta = {1'b0, cur} - {1'b0, prev}
            + (ovf ? 33'h1_0000_0000 : 33'h0);
    endfunction : energy_delta
endmodule : host_model

// >>> tb/tb_phase_energy_accumulators.sv
// Self-checking bench for the phase energy accumulator bank
`timescale 1ns/100ps
module tb_phase_energy_accumulators;
    import energy_acc_pkg::*;
    logic clk;
    logic rst;
    logic dsp_cycle_done;
    phase_in_s [2:0] phase_in;
    host_req_s host_req;
    host_rsp_s host_rsp;
    int err_count;
    int n_checks;
    logic [DATA_W-1:0] e_rms [3];
    logic [DATA_W-1:0] e_pos [3];
    logic [DATA_W-1:0] e_neg [3];
    logic [DATA_W-1:0] e_rp [3];
    logic [2:0] e_ovf [3];
    logic [DATA_W-1:0] rd_d;
    logic [DATA_W-1:0] pv;
    logic [32:0] dl;
    logic rd_v;

    phase_energy_accumulators u_dut (.clk(clk), .rst(rst),
        .dsp_cycle_done(dsp_cycle_done), .phase_in(phase_in),
        .host_req(host_req), .host_rsp(host_rsp));
    host_model u_host (.clk(clk), .host_req(host_req),
        .host_rsp(host_rsp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cmp(input string w, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : cmp

    task automatic rd_cmp(input string w, input logic [ADDR_W-1:0] a,
        input logic [31:0] e);
        u_host.rd(a, rd_d, rd_v);
        cmp({w, " valid"}, 32'h1, {31'h0, rd_v});
        cmp(w, e, rd_d);
    endtask : rd_cmp

    // One DSP pulse; only phase p carries power, stale power is zeroed
    task automatic dsp(input int p, input logic [31:0] re,
        input logic [31:0] rq, input logic [31:0] rms);
        logic [32:0] s;
        @(posedge clk);
        #1;
        for (int q = 0; q < 3; q++) begin
            phase_in[q].signed_real_power = '0;
            phase_in[q].signed_reactive_power = '0;
        end
        phase_in[p] = {re, rq, rms};
        dsp_cycle_done = 1'b1;
        e_rms[p] = rms;
        if (!re[31] && re != 0) begin
            s = {1'b0, e_pos[p]} + {1'b0, re};
            e_pos[p] = s[31:0];
            if (s[32]) e_ovf[p][REAL_POS_OVF_BIT] = 1'b1;
        end
        if (re[31]) begin
            s = {1'b0, e_neg[p]} + {1'b0, ~re + 32'h1};
            e_neg[p] = s[31:0];
            if (s[32]) e_ovf[p][REAL_NEG_OVF_BIT] = 1'b1;
        end
        if (!rq[31] && rq != 0) begin
            s = {1'b0, e_rp[p]} + {1'b0, rq};
            e_rp[p] = s[31:0];
            if (s[32]) e_ovf[p][REACT_POS_OVF_BIT] = 1'b1;
        end
        @(posedge clk);
        #1;
        dsp_cycle_done = 1'b0;
    endtask : dsp

    task automatic chk_phase(input int p);
        rd_cmp("rms current", RMS_CURRENT_OFS[p], e_rms[p]);
        rd_cmp("real pos", REAL_POS_OFS[p], e_pos[p]);
        rd_cmp("real neg", REAL_NEG_OFS[p], e_neg[p]);
        rd_cmp("react pos", REACT_POS_OFS[p], e_rp[p]);
        rd_cmp("flags", OVF_FLAGS_OFS[p], {29'h0, e_ovf[p]});
    endtask : chk_phase

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Tests need well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        complete_run;
    end

    initial begin
        rst = 1'b1;
        dsp_cycle_done = 1'b0;
        phase_in = '0;
        err_count = 0;
        n_checks = 0;
        for (int p = 0; p < 3; p++) begin
            e_rms[p] = '0;
            e_pos[p] = '0;
            e_neg[p] = '0;
            e_rp[p] = '0;
            e_ovf[p] = '0;
        end
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int p = 0; p < 3; p++) chk_phase(p);
        $display("test reset values done");
        // Distinct RMS, real positive and reactive values per phase catch swapped addresses
        for (int p = 0; p < 3; p++) begin
            dsp(p, 32'h100 + p, 32'h30 + p, 32'h00AB_0000 + p);
            dsp(p, 32'hFFFF_FF00, 32'hFFFF_FFF0, 32'h0012_3400);
            dsp(p, 32'h0, 32'h0, 32'h0000_0001 + p);
        end
        for (int p = 0; p < 3; p++) chk_phase(p);
        $display("test sign steering done");
        // Wrap every accumulator of phase A, the phase the checks watch
        dsp(0, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h0);
        pv = e_pos[0];
        dsp(0, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h0);
        dsp(0, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0);
        dsp(0, 32'h8000_0000, 32'h0, 32'h0);
        chk_phase(0);
        u_host.rd(REAL_POS_OFS[0], rd_d, rd_v);
        dl = u_host.energy_delta(pv, rd_d, e_ovf[0][REAL_POS_OVF_BIT]);
        cmp("real pos delta", 32'h7FFF_FFFF, dl[31:0]);
        $display("test wrap and flags done");
        // Flags survive updates, clear bit by bit, and a new wrap wins over a same-cycle clear
        dsp(0, 32'h1, 32'h0, 32'h0);
        chk_phase(0);
        u_host.clr(OVF_FLAGS_OFS[0], 8'h01);
        e_ovf[0][REAL_POS_OVF_BIT] = 1'b0;
        rd_cmp("flags part", OVF_FLAGS_OFS[0], {29'h0, e_ovf[0]});
        u_host.clr(OVF_FLAGS_OFS[0], 8'hFF);
        e_ovf[0] = 3'h0;
        rd_cmp("flags clear", OVF_FLAGS_OFS[0], 32'h0);
        fork
            dsp(0, 32'h0, 32'h7FFF_FFFF, 32'h0);
            u_host.clr(OVF_FLAGS_OFS[0], 8'h04);
        join
        rd_cmp("flags collide", OVF_FLAGS_OFS[0], {29'h0, e_ovf[0]});
        chk_phase(0);
        chk_phase(1);
        $display("test flag clear done");
        rd_cmp("unmapped", 10'h000, 32'h0);
        $display("test unmapped done");
        complete_run;
    end
endmodule : tb_phase_energy_accumulators
